// ---- inc/abw_pkg.sv ----
// Register map, field layout, reset values and decode codes of the area bus control block
// =====================================================================
package abw_pkg;
    // =================================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [3:0]  ADDR_WIDTH_CFG = 4'h0;
    localparam logic [3:0]  ADDR_WAIT_CFG  = 4'h4;
    localparam logic [3:0]  ADDR_DYN_CFG   = 4'h8;
    localparam logic [3:0]  ADDR_GEN_CFG   = 4'hC;
    // =================================================================
    // Reset values
    localparam logic [15:0] RST_WIDTH_CFG  = 16'h00FC;
    localparam logic [15:0] RST_WAIT_CFG   = 16'hAAFF;
    localparam logic [15:0] RST_DYN_CFG    = 16'h0000;
    localparam logic [15:0] RST_GEN_CFG    = 16'h03F0;
    // Writable bits
    localparam logic [15:0] MASK_WIDTH_CFG = 16'h00FC;
    localparam logic [15:0] MASK_DYN_CFG   = 16'hFEFC;
    localparam logic [15:0] MASK_GEN_CFG   = 16'h1FF7;
    // =================================================================
    // Field positions
    localparam int WIDTH_A1_LSB = 2;
    localparam int IDLE_LSB     = 8;
    localparam int WAIT_LSB     = 0;
    localparam int LW_A0_LSB    = 4;
    localparam int LW_A1_LSB    = 6;
    localparam int LW_A23_LSB   = 8;
    localparam int MTYPE_LSB    = 0;
    // =================================================================
    // Width codes
    localparam logic [1:0] SZ_RSVD = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_HALF = 2'h2;
    localparam logic [1:0] SZ_WORD = 2'h3;
    // Wait and long wait codes
    localparam logic [1:0] WT_LONG = 2'h3;
    localparam logic [2:0] LW_BASE = 3'h3;
    // Memory kind of an access
    typedef enum logic [1:0] {
        MK_PLAIN = 2'h0,
        MK_SDRAM = 2'h1,
        MK_DRAM  = 2'h2,
        MK_PSRAM = 2'h3
    } abw_kind_t;
    // Memory type field values
    localparam logic [2:0] MT_A3_SDRAM  = 3'h1;
    localparam logic [2:0] MT_A3_DRAM   = 3'h2;
    localparam logic [2:0] MT_A3_PSRAM  = 3'h3;
    localparam logic [2:0] MT_A2_SDRAM  = 3'h4;
    localparam logic [2:0] MT_BOTH_SDRAM = 3'h5;
    localparam logic [1:0] AREA2 = 2'h2;
    localparam logic [1:0] AREA3 = 2'h3;
endpackage

// ---- rtl/abw_area_timing.sv ----
// Per-access decoder: turns configuration fields into width, idle, wait and kind
`timescale 1ns/100ps
module abw_area_timing (
    input  wire logic [1:0]  area_i,
    input  wire logic [15:0] width_cfg_i,
    input  wire logic [15:0] wait_cfg_i,
    input  wire logic [15:0] gen_cfg_i,
    input  wire logic [1:0]  area0_width_i,
    output logic      [1:0]  width_o,
    output logic      [1:0]  idle_o,
    output logic      [2:0]  wait_o,
    output logic      [2:0]  cas_o,
    output logic             ext_wait_en_o,
    output abw_pkg::abw_kind_t kind_o
);
    logic [1:0] wcode;
    logic [1:0] lcode;
    logic [2:0] mtype;

    // =================================================================
    // Field select and kind decode
    always_comb begin
        wcode  = wait_cfg_i[abw_pkg::WAIT_LSB + 2*area_i +: 2];
        idle_o = wait_cfg_i[abw_pkg::IDLE_LSB + 2*area_i +: 2];
        mtype  = gen_cfg_i[abw_pkg::MTYPE_LSB +: 3];
        case (area_i)
            2'h0:    lcode = gen_cfg_i[abw_pkg::LW_A0_LSB +: 2];
            2'h1:    lcode = gen_cfg_i[abw_pkg::LW_A1_LSB +: 2];
            default: lcode = gen_cfg_i[abw_pkg::LW_A23_LSB +: 2];
        endcase
        kind_o = abw_pkg::MK_PLAIN;
        if (area_i == abw_pkg::AREA3) begin
            case (mtype)
                abw_pkg::MT_A3_SDRAM, abw_pkg::MT_BOTH_SDRAM: kind_o = abw_pkg::MK_SDRAM;
                abw_pkg::MT_A3_DRAM:  kind_o = abw_pkg::MK_DRAM;
                abw_pkg::MT_A3_PSRAM: kind_o = abw_pkg::MK_PSRAM;
                default:              kind_o = abw_pkg::MK_PLAIN;
            endcase
        end else if (area_i == abw_pkg::AREA2) begin
            if (mtype == abw_pkg::MT_A2_SDRAM || mtype == abw_pkg::MT_BOTH_SDRAM) begin
                kind_o = abw_pkg::MK_SDRAM;
            end
        end
    end

    // =================================================================
    // Width: area 0 from pins, other plain areas from the size fields
    always_comb begin
        if (area_i == 2'h0) begin
            width_o = area0_width_i;
        end else if (kind_o != abw_pkg::MK_PLAIN) begin
            width_o = abw_pkg::SZ_RSVD;  // Dynamic memories take width elsewhere
        end else begin
            width_o = width_cfg_i[abw_pkg::WIDTH_A1_LSB + 2*(area_i - 2'h1) +: 2];
        end
    end

    // =================================================================
    // Wait count, CAS span and external wait enable per memory kind
    always_comb begin
        wait_o        = 3'h0;
        cas_o         = 3'h0;
        ext_wait_en_o = 1'b0;
        case (kind_o)
            abw_pkg::MK_DRAM: begin
                cas_o         = {1'b0, wcode} + 3'h1;
                ext_wait_en_o = (wcode != 2'h0);
            end
            abw_pkg::MK_SDRAM: begin
                cas_o         = {1'b0, wcode} + 3'h1;
                ext_wait_en_o = 1'b0;
            end
            abw_pkg::MK_PSRAM: begin
                cas_o         = {1'b0, wcode} + 3'h2;
                ext_wait_en_o = (wcode != 2'h0);
            end
            default: begin
                if (wcode == abw_pkg::WT_LONG) begin
                    wait_o = abw_pkg::LW_BASE + {1'b0, lcode};
                end else begin
                    wait_o = {1'b0, wcode};
                end
                ext_wait_en_o = (wcode != 2'h0);
            end
        endcase
    end
endmodule

// ---- rtl/abw_bus_control.sv ----
// Area bus width, idle and wait control with Wishbone register slave
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/100ps
module abw_bus_control (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Mode pins giving area 0 width
    input  wire logic [1:0]  area0_width_i,
    // Access sequencing from the bus state machine
    input  wire logic        acc_req_i,
    input  wire logic [1:0]  acc_area_i,
    input  wire logic        acc_write_i,
    output logic             acc_start_o,
    output logic      [1:0]  acc_idle_o,
    output logic      [1:0]  acc_width_o,
    output logic      [2:0]  acc_wait_o,
    output logic      [2:0]  acc_cas_o,
    output logic             acc_ext_wait_en_o,
    output logic      [1:0]  acc_kind_o
);
    // =================================================================
    // Idle sequencer states, Gray along idle path
    typedef enum logic [1:0] {
        ST_READY = 2'b00,
        ST_IDLE  = 2'b01,
        ST_GO    = 2'b11
    } abw_state_t;

    abw_state_t state_q;
    logic [15:0] width_cfg_q;
    logic [15:0] wait_cfg_q;
    logic [15:0] dyn_cfg_q;
    logic [15:0] gen_cfg_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        have_prev_q;
    logic [1:0]  prev_area_q;
    logic        prev_write_q;
    logic [1:0]  prev_idle_q;
    logic [1:0]  idle_cnt_q;
    logic        start_q;
    logic [1:0]  idle_out_q;
    logic [1:0]  width_q;
    logic [2:0]  wait_q;
    logic [2:0]  cas_q;
    logic        ext_q;
    logic [1:0]  kind_q;

    logic        wb_hit;
    logic [15:0] wmask;
    logic [15:0] rsel;
    logic [1:0]  dec_width;
    logic [1:0]  dec_idle;
    logic [2:0]  dec_wait;
    logic [2:0]  dec_cas;
    logic        dec_ext;
    abw_pkg::abw_kind_t dec_kind;
    logic        need_idle;

    // =================================================================
    // Decoder for the area about to be accessed
    abw_area_timing u_timing (
        .area_i        (acc_area_i),
        .width_cfg_i   (width_cfg_q),
        .wait_cfg_i    (wait_cfg_q),
        .gen_cfg_i     (gen_cfg_q),
        .area0_width_i (area0_width_i),
        .width_o       (dec_width),
        .idle_o        (dec_idle),
        .wait_o        (dec_wait),
        .cas_o         (dec_cas),
        .ext_wait_en_o (dec_ext),
        .kind_o        (dec_kind)
    );

    // =================================================================
    // Wishbone decode; only the two low byte lanes carry register bits
    assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;
    assign wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        case (wb_adr_i)
            abw_pkg::ADDR_WIDTH_CFG: rsel = width_cfg_q & abw_pkg::MASK_WIDTH_CFG;
            abw_pkg::ADDR_WAIT_CFG:  rsel = wait_cfg_q;
            abw_pkg::ADDR_DYN_CFG:   rsel = dyn_cfg_q;
            abw_pkg::ADDR_GEN_CFG:   rsel = gen_cfg_q;
            default:                 rsel = 16'h0000;  // Unmapped reads as zero
        endcase
    end

    // Ack one cycle after the strobe, dropped the next cycle
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= wb_hit;
            rdat_q <= wb_hit ? {16'h0000, rsel} : 32'h0000_0000;
        end
    end

    // =================================================================
    // Configuration registers; reserved bits never store a one
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            width_cfg_q <= abw_pkg::RST_WIDTH_CFG;
            wait_cfg_q  <= abw_pkg::RST_WAIT_CFG;
            dyn_cfg_q   <= abw_pkg::RST_DYN_CFG;
            gen_cfg_q   <= abw_pkg::RST_GEN_CFG;
        end else if (wb_hit && wb_we_i) begin
            // Rewrites are accepted; software is expected to repeat the same values
            case (wb_adr_i)
                abw_pkg::ADDR_WIDTH_CFG: width_cfg_q <= (width_cfg_q & ~wmask) |
                    (wb_dat_i[15:0] & wmask & abw_pkg::MASK_WIDTH_CFG);
                abw_pkg::ADDR_WAIT_CFG:  wait_cfg_q <= (wait_cfg_q & ~wmask) |
                    (wb_dat_i[15:0] & wmask);
                abw_pkg::ADDR_DYN_CFG:   dyn_cfg_q <= (dyn_cfg_q & ~wmask) |
                    (wb_dat_i[15:0] & wmask & abw_pkg::MASK_DYN_CFG);
                abw_pkg::ADDR_GEN_CFG:   gen_cfg_q <= (gen_cfg_q & ~wmask) |
                    (wb_dat_i[15:0] & wmask & abw_pkg::MASK_GEN_CFG);
                default: ;
            endcase
        end
    end

    // =================================================================
    // Idle needed on area change or read then write
    assign need_idle = have_prev_q &&
                       ((acc_area_i != prev_area_q) ||
                        (!prev_write_q && acc_write_i)) &&
                       (prev_idle_q != 2'h0);

    // Sequencer: count idles from the previous area, then release the access
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q    <= ST_READY;
            idle_cnt_q <= 2'h0;
        end else begin
            case (state_q)
                ST_READY: begin
                    if (acc_req_i) begin
                        if (need_idle) begin
                            state_q    <= ST_IDLE;
                            idle_cnt_q <= prev_idle_q;
                        end else begin
                            state_q <= ST_GO;
                        end
                    end
                end
                ST_IDLE: begin
                    if (idle_cnt_q == 2'h1) begin
                        state_q <= ST_GO;
                    end
                    idle_cnt_q <= idle_cnt_q - 2'h1;
                end
                ST_GO: begin
                    state_q <= ST_READY;
                end
                default: begin
                    state_q <= ST_READY;
                end
            endcase
        end
    end

    // Remember the area just started, its direction and its idle setting
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            have_prev_q  <= 1'b0;
            prev_area_q  <= 2'h0;
            prev_write_q <= 1'b0;
            prev_idle_q  <= 2'h0;
        end else if (state_q == ST_GO) begin
            have_prev_q  <= 1'b1;
            prev_area_q  <= acc_area_i;
            prev_write_q <= acc_write_i;
            prev_idle_q  <= dec_idle;
        end
    end

    // =================================================================
    // Registered access outputs; requester holds area and direction until start
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            start_q    <= 1'b0;
            idle_out_q <= 2'h0;
            width_q    <= 2'h0;
            wait_q     <= 3'h0;
            cas_q      <= 3'h0;
            ext_q      <= 1'b0;
            kind_q     <= 2'h0;
        end else begin
            start_q <= (state_q == ST_GO);
            // Idle count moves with the other results, so nothing changes between starts
            if (state_q == ST_GO) begin
                idle_out_q <= need_idle ? prev_idle_q : 2'h0;
                width_q <= dec_width;
                wait_q  <= dec_wait;
                cas_q   <= dec_cas;
                ext_q   <= dec_ext;
                kind_q  <= dec_kind;
            end
        end
    end

    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = rdat_q;
    assign acc_start_o       = start_q;
    assign acc_idle_o        = idle_out_q;
    assign acc_width_o       = width_q;
    assign acc_wait_o        = wait_q;
    assign acc_cas_o         = cas_q;
    assign acc_ext_wait_en_o = ext_q;
    assign acc_kind_o        = kind_q;
endmodule

// ---- testbench/abw_bus_sva.sv ----
// Assertion checker for the area bus control block
`timescale 1ns/100ps
module abw_bus_sva (
    input wire logic        mclk_i,
    input wire logic        reset_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [1:0]  area0_width_i,
    input wire logic        acc_req_i,
    input wire logic [1:0]  acc_area_i,
    input wire logic        acc_start_o,
    input wire logic [1:0]  acc_idle_o,
    input wire logic [1:0]  acc_width_o,
    input wire logic [2:0]  acc_wait_o,
    input wire logic [2:0]  acc_cas_o,
    input wire logic        acc_ext_wait_en_o,
    input wire logic [1:0]  acc_kind_o
);
    // =================================================================
    // Clocking and access steps
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence s_take;
        $rose(acc_req_i);
    endsequence
    sequence s_answer;
        !acc_start_o ##[1:3] acc_start_o;
    endsequence
    // =================================================================
    // Register slave
    AST_WB_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not one pulse one cycle after the request");
    AST_RSV_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |->
        (wb_dat_o & 32'hFFFF_FF03) == 32'h0000_0000)
        else $error("reserved size bits read nonzero");
    AST_NO_ACK_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data nonzero outside ack");
    // =================================================================
    // Access sequencing, two cycles plus up to two idles
    AST_IDLE_LATENCY: assert property (s_take |=> s_answer)
        else $error("start not two to four cycles after request");
    AST_START_PULSE: assert property (acc_start_o |=> !acc_start_o)
        else $error("start longer than one cycle");
    AST_IDLE_RANGE: assert property (acc_start_o |-> acc_idle_o <= 2'h2)
        else $error("idle count above two");
    AST_HOLD: assert property (!acc_start_o && !$past(reset_i) |->
        $stable(acc_cas_o) && $stable(acc_kind_o) && $stable(acc_idle_o))
        else $error("results changed without a start");
    // =================================================================
    // Decoded timing per memory kind
    AST_AREA0_WIDTH: assert property (acc_start_o && acc_area_i == 2'h0 |->
        acc_width_o == area0_width_i)
        else $error("area 0 width not from mode pins");
    AST_PLAIN: assert property (acc_start_o && acc_kind_o == 2'h0 |->
        acc_cas_o == 3'h0 && acc_ext_wait_en_o == (acc_wait_o != 3'h0))
        else $error("plain wait decode wrong");
    AST_DYN_WIDTH: assert property (acc_start_o && acc_kind_o != 2'h0 |->
        acc_width_o == 2'h0 && acc_wait_o == 3'h0)
        else $error("size field used for dynamic memory");
    AST_DRAM: assert property (acc_start_o && acc_kind_o == abw_pkg::MK_DRAM |->
        acc_cas_o inside {[1:3]} && acc_ext_wait_en_o == (acc_cas_o >= 3'h2))
        else $error("dram cas decode wrong");
    AST_PSRAM: assert property (acc_start_o && acc_kind_o == abw_pkg::MK_PSRAM |->
        acc_cas_o inside {[2:4]} && acc_ext_wait_en_o == (acc_cas_o >= 3'h3))
        else $error("pseudo sram span decode wrong");
    AST_SDRAM: assert property (acc_start_o && acc_kind_o == abw_pkg::MK_SDRAM |->
        acc_cas_o inside {[1:4]} && !acc_ext_wait_en_o)
        else $error("sdram latency decode wrong");
endmodule
bind abw_bus_control abw_bus_sva chk_u (.*);

// ---- testbench/abw_seq_model.sv ----
// Behavioural bus sequencer that asks the block for access timing
`timescale 1ns/100ps
module abw_seq_model (
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       go_i,
    input  wire logic [1:0] area_i,
    input  wire logic       write_i,
    input  wire logic       acc_start_i,
    output logic            acc_req_o,
    output logic      [1:0] acc_area_o,
    output logic            acc_write_o
);
    logic req_q;
    // Hold area and direction until the start pulse; reset parks on the boot area
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            req_q <= 1'b0;
            acc_area_o <= 2'h0;
            acc_write_o <= 1'b0;
        end else if (go_i) begin
            req_q <= 1'b1;
            acc_area_o <= area_i;
            acc_write_o <= write_i;
        end else if (acc_start_i) begin
            req_q <= 1'b0;
        end
    end
    // Masked in the start cycle, otherwise the held request is taken twice
    assign acc_req_o = req_q & ~acc_start_i;
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the area bus control block
`timescale 1ns/100ps
module testbench;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [3:0]  sel = 4'h3;
    logic [31:0] wb_dat_o, rd;
    logic        wb_ack_o, acc_req_i, acc_write_i, acc_start_o, acc_ext_wait_en_o;
    logic [1:0]  area0_width_i = 2'h2;
    logic        go = 1'b0;
    logic        wr = 1'b0;
    logic [1:0]  area = 2'h0;
    logic [1:0]  acc_area_i, acc_idle_o, acc_width_o, acc_kind_o;
    logic [2:0]  acc_wait_o, acc_cas_o;
    int          failures = 0;
    int          num_checks = 0;
    // =================================================================
    // Clock, design and sequencer
    always #25 mclk_i = ~mclk_i;
    abw_bus_control dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .area0_width_i(area0_width_i), .acc_req_i(acc_req_i), .acc_area_i(acc_area_i),
        .acc_write_i(acc_write_i), .acc_start_o(acc_start_o), .acc_idle_o(acc_idle_o),
        .acc_width_o(acc_width_o), .acc_wait_o(acc_wait_o), .acc_cas_o(acc_cas_o),
        .acc_ext_wait_en_o(acc_ext_wait_en_o), .acc_kind_o(acc_kind_o));
    abw_seq_model seq_u (.mclk_i(mclk_i), .reset_i(reset_i), .go_i(go), .area_i(area),
        .write_i(wr), .acc_start_i(acc_start_o), .acc_req_o(acc_req_i),
        .acc_area_o(acc_area_i), .acc_write_o(acc_write_i));
    // =================================================================
    // Checking and bus tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // A wait that runs out ends the run at once
    task automatic tmo(input int n);
        if (n >= 20) begin
            failures++;
            report_and_stop();
        end
    endtask
    // One classic cycle; master holds everything until ack is sampled
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        tmo(n);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rdc(input logic [3:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0000_0000);
        chk("register", exp, rd);
    endtask
    function automatic logic [12:0] ex(input int i, wd, wt, c, x, k);
        return {i[1:0], wd[1:0], wt[2:0], c[2:0], x[0], k[1:0]};
    endfunction
    // Request one access; start is due 2 + idles cycles after it is taken
    task automatic acc(input logic [1:0] a, input logic w, input logic [12:0] exp);
        int n;
        n = 1;
        go <= 1'b1;
        area <= a;
        wr <= w;
        @(posedge mclk_i);
        go <= 1'b0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (acc_start_o !== 1'b1 && n < 20);
        tmo(n);
        chk("latency", 32'(4 + exp[12:11]), 32'(n));
        chk("result", 32'(exp), 32'({acc_idle_o, acc_width_o, acc_wait_o, acc_cas_o,
            acc_ext_wait_en_o, acc_kind_o}));
    endtask
    // =================================================================
    // Test sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        rdc(4'h0, 32'h0000_00FC);
        rdc(4'h4, 32'h0000_AAFF);
        rdc(4'h8, 32'h0000_0000);
        rdc(4'hC, 32'h0000_03F0);
        rdc(4'h2, 32'h0000_0000);
        $display("test reset values done");
        wb(1'b1, 4'h0, 32'hFFFF_FF97);
        rdc(4'h0, 32'h0000_0094);
        wb(1'b1, 4'h8, 32'hFFFF_FFFF);
        rdc(4'h8, 32'h0000_FEFC);
        wb(1'b1, 4'h4, 32'h0000_241B);
        rdc(4'h4, 32'h0000_241B);
        $display("test register access done");
        acc(2'h0, 1'b0, ex(0, 2, 6, 0, 1, 0));
        acc(2'h1, 1'b0, ex(0, 1, 2, 0, 1, 0));
        acc(2'h2, 1'b0, ex(1, 1, 1, 0, 1, 0));
        acc(2'h2, 1'b1, ex(2, 1, 1, 0, 1, 0));
        acc(2'h2, 1'b1, ex(0, 1, 1, 0, 1, 0));
        acc(2'h3, 1'b0, ex(2, 2, 0, 0, 0, 0));
        acc(2'h1, 1'b0, ex(0, 1, 2, 0, 1, 0));
        area0_width_i <= 2'h3;
        acc(2'h0, 1'b1, ex(1, 3, 6, 0, 1, 0));
        wb(1'b1, 4'hC, 32'h0000_03D0);
        acc(2'h0, 1'b0, ex(0, 3, 4, 0, 1, 0));
        $display("test idle and wait done");
        // Idles cleared so each access starts without gaps
        for (int t = 1; t < 4; t++) begin
            wb(1'b1, 4'hC, 32'h0000_03F0 | 32'(t));
            for (int c = 0; c < 4; c++) begin
                if (c < 3 || t == 1) begin
                    wb(1'b1, 4'h4, 32'(c) << 6);
                    acc(2'h3, 1'b0, ex(0, 0, 0, c + 1 + (t == 3), t != 1 && c > 0, t));
                end
            end
        end
        wb(1'b1, 4'hC, 32'h0000_03F4);
        wb(1'b1, 4'h4, 32'h0000_0030);
        acc(2'h2, 1'b0, ex(0, 0, 0, 4, 0, 1));
        acc(2'h3, 1'b1, ex(0, 2, 0, 0, 0, 0));
        wb(1'b1, 4'hC, 32'h0000_03F5);
        acc(2'h3, 1'b0, ex(0, 0, 0, 1, 0, 1));
        acc(2'h2, 1'b0, ex(0, 0, 0, 4, 0, 1));
        $display("test memory kinds done");
        // Upper byte lane alone: the low byte must keep its value
        sel = 4'h2;
        wb(1'b1, 4'h4, 32'h0000_1234);
        sel = 4'h3;
        rdc(4'h4, 32'h0000_1230);
        $display("test byte lanes done");
        report_and_stop();
    end
endmodule
